/* File: core/e1_ovh_pkg.sv */
// Constants, register map and carrier types for the E1 event and transmit overhead block.
// Assumes one 20 MHz clock and eight channels sharing one AXI4-Lite slave.
// ****************************************************************
// What this block does
// - Selected national nibble readable in four bits, first received bit in MSB.
// - Reported nibble changes only after two successive identical nibbles.
// - Eight channel copies of each register, spaced 0x80 in index.
// - Reading the event register clears all its flags.
// - Offline frame loss flag sets on any change of its state input.
// - V5.2 link id flag sets on any toggle of its state input.
// - Remote alarm plus far-end error persisting 10 ms sets its flag.
// - Over 990 far-end errors per second for 5 seconds sets flag.
// - Separate flags for frame, sub-multiframe, multiframe and signaling multiframe starts.
// - Interrupt pin driven only for flags whose enable is one; enables reset zero.
// - FIFO reinit bit one holds generator in init, zero resumes.
// - TS16 source 00 passes input TS16; host also sets extra bits bypass.
// - TS16 source 11 takes per-slot signaling, frame 0 gets alignment pattern.
// - TS16 source selection applies only while all-ones alarm force is zero.
// - CRC off: insert programmed cross-border bits unless bypassed, then pass input.
// - CRC on, cross-border bypass off: insert alignment pattern and CRC-4 of previous sub-multiframe.
// - CRC on with reporting: E bits carry far-end errors; needs FAS insert on.
// - FAS insert on: timeslot 0 of FAS frames carries alignment sequence.
// - FAS insert off: data passes unchanged; CRC, report and bypass bits ignored.
// - Nibble select codes 100-111 pick Sa4-Sa7, 000 picks Sa8.
// ****************************************************************
package e1_ovh_pkg;

  localparam int NCH = 8;
  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_NIB_SEL = 7'h3b;
  localparam logic [6:0] IDX_NIBBLE = 7'h3d;
  localparam logic [6:0] IDX_IRQ_EN = 7'h3e;
  localparam logic [6:0] IDX_FLAGS = 7'h3f;
  localparam logic [6:0] IDX_TX_CFG = 7'h40;
  localparam int CH_STRIDE = 'h80;

  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_TX_CFG = 8'h60;
  localparam logic [2:0] RST_NIB_SEL = 3'h0;

  // Event flag and enable bit positions
  localparam int B_OOF = 7;
  localparam int B_RAI = 6;
  localparam int B_PFEBE = 5;
  localparam int B_V52 = 4;
  localparam int B_BF = 3;
  localparam int B_SMF = 2;
  localparam int B_MF = 1;
  localparam int B_SIGMF = 0;

  // Transmit configuration bit positions
  localparam int C_REINIT = 7;
  localparam int C_SRC_HI = 6;
  localparam int C_SRC_LO = 5;
  localparam int C_CRC_ON = 4;
  localparam int C_FAS_OFF = 3;
  localparam int C_FEBE_OFF = 2;
  localparam int C_XB_BYP = 1;
  localparam int C_EXTRA_BYP = 0;

  // Overhead patterns and programmed defaults
  localparam logic [6:0] FAS_PATTERN = 7'h1b;
  localparam logic [5:0] MFAS_PATTERN = 6'h0b;
  localparam logic [1:0] SI_DEFAULT = 2'h3;
  localparam logic [2:0] EXTRA_DEFAULT = 3'h7;
  localparam logic [3:0] SIGMF_ALIGN = 4'h0;

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RAI_PERSIST_MS = 10;
  localparam int RAI_CYCLES = CLK_HZ / 1000 * RAI_PERSIST_MS;
  localparam int SECOND_CYCLES = CLK_HZ;
  localparam logic [9:0] FEBE_LIMIT = 10'd990;
  localparam logic [2:0] FEBE_SECONDS = 3'd5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic basic_frame_start;
    logic crc_submf_start;
    logic crc_mf_start;
    logic sig_mf_start;
    logic nfas_strobe;
    logic [4:0] sa_bits;
    logic a_bit;
    logic e_strobe;
    logic [1:0] e_bits;
    logic offline_frame_loss_state;
    logic v52_link_id_state;
  } rx_in_t;

  typedef struct packed {
    logic valid;
    logic [3:0] frame;
    logic [4:0] ts;
    logic [7:0] data;
    logic [7:0] sig;
    logic [7:0] ctrl;
    logic use_ctrl;
    logic sig_mf_frame0;
    logic all_ones_force;
    logic [1:0] far_crc_ok;
  } tx_in_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tx_out_t;

endpackage : e1_ovh_pkg

/* File: core/e1_ovh_core.sv */
// Eight-channel E1 receive event reporting and transmit overhead insertion.
// Assumes receive and transmit strobes synchronous to aclk, at most one byte per cycle.
`timescale 1ns/1ns
`default_nettype none
module e1_ovh_core #(
  parameter int RAI_PERSIST_CYCLES = e1_ovh_pkg::RAI_CYCLES,
  parameter int ONE_SECOND_CYCLES = e1_ovh_pkg::SECOND_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [e1_ovh_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [e1_ovh_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receive framer events
  input wire e1_ovh_pkg::rx_in_t rx_in [e1_ovh_pkg::NCH],
  // Transmit data path
  input wire e1_ovh_pkg::tx_in_t tx_in [e1_ovh_pkg::NCH],
  output e1_ovh_pkg::tx_out_t tx_out [e1_ovh_pkg::NCH],
  output logic [e1_ovh_pkg::NCH-1:0] tx_fifo_reinit,
  // Interrupt
  output logic irq_n
);
  import e1_ovh_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic pick_sa(input logic [2:0] sel, input logic [4:0] sa);
    case (sel)
      3'h4: pick_sa = sa[4];
      3'h5: pick_sa = sa[3];
      3'h6: pick_sa = sa[2];
      3'h7: pick_sa = sa[1];
      3'h0: pick_sa = sa[0];
      default: pick_sa = 1'b0;
    endcase
  endfunction : pick_sa

  // CRC-4, x^4 + x + 1, MSB of the byte first
  function automatic logic [3:0] crc4_byte(input logic [3:0] c, input logic [7:0] b);
    logic [3:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[3] ^ b[i];
      r = {r[2], r[1], r[0] ^ fb, fb};
    end
    return r;
  endfunction : crc4_byte

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] irq_en_q [NCH];
  logic [7:0] flags_q [NCH];
  logic [7:0] tx_cfg_q [NCH];
  logic [2:0] nib_sel_q [NCH];
  logic [3:0] nibble_q [NCH];
  logic [7:0] ev [NCH];

  // AXI state
  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic do_write;
  logic [9:0] widx;
  logic [9:0] ridx;
  logic rd_take;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic wr_ok;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign widx = awaddr_q[ADDR_W-1:2];
  assign ridx = s_axi_araddr[ADDR_W-1:2];
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Channel copies sit at index + 0x80 * channel
  always_comb begin
    wr_ok = (widx[6:0] == IDX_NIB_SEL) || (widx[6:0] == IDX_IRQ_EN) ||
            (widx[6:0] == IDX_TX_CFG);
    rd_ok = 1'b1;
    case (ridx[6:0])
      IDX_NIB_SEL: rd_byte = {nib_sel_q[ridx[9:7]], 5'h00};
      IDX_NIBBLE: rd_byte = {4'h0, nibble_q[ridx[9:7]]};
      IDX_IRQ_EN: rd_byte = irq_en_q[ridx[9:7]];
      IDX_FLAGS: rd_byte = flags_q[ridx[9:7]];
      IDX_TX_CFG: rd_byte = tx_cfg_q[ridx[9:7]];
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rd_byte};
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software-written control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        irq_en_q[c] <= RST_IRQ_EN;
        tx_cfg_q[c] <= RST_TX_CFG;
        nib_sel_q[c] <= RST_NIB_SEL;
      end
    end else if (do_write && wstrb0_q) begin
      case (widx[6:0])
        IDX_NIB_SEL: nib_sel_q[widx[9:7]] <= wdata_q[7:5];
        IDX_IRQ_EN: irq_en_q[widx[9:7]] <= wdata_q;
        IDX_TX_CFG: tx_cfg_q[widx[9:7]] <= wdata_q;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Receive events
  // ****************************************************************
  logic primed_q;
  logic oof_prev_q [NCH];
  logic v52_prev_q [NCH];
  logic a_q [NCH];
  logic febe_q [NCH];
  logic [17:0] rai_cnt_q [NCH];
  logic [9:0] febe_cnt_q [NCH];
  logic [2:0] streak_q [NCH];
  logic [24:0] sec_cnt_q;
  logic sec_tick;
  logic [9:0] febe_add [NCH];
  logic [9:0] febe_sum [NCH];

  assign sec_tick = (sec_cnt_q == 25'(ONE_SECOND_CYCLES - 1));

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      febe_add[c] = rx_in[c].e_strobe ?
                    10'({1'b0, ~rx_in[c].e_bits[1]} + {1'b0, ~rx_in[c].e_bits[0]}) : 10'h0;
      febe_sum[c] = (febe_cnt_q[c] > 10'h3fd) ? 10'h3ff : febe_cnt_q[c] + febe_add[c];
      ev[c] = 8'h00;
      ev[c][B_OOF] = primed_q &&
                     (rx_in[c].offline_frame_loss_state != oof_prev_q[c]);
      ev[c][B_V52] = primed_q && (rx_in[c].v52_link_id_state != v52_prev_q[c]);
      ev[c][B_RAI] = a_q[c] && febe_q[c] &&
                     (rai_cnt_q[c] == 18'(RAI_PERSIST_CYCLES - 1));
      ev[c][B_PFEBE] = sec_tick && (febe_sum[c] > FEBE_LIMIT) &&
                       (streak_q[c] == FEBE_SECONDS - 3'd1);
      ev[c][B_BF] = rx_in[c].basic_frame_start;
      ev[c][B_SMF] = rx_in[c].crc_submf_start;
      ev[c][B_MF] = rx_in[c].crc_mf_start;
      ev[c][B_SIGMF] = rx_in[c].sig_mf_start;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed_q <= 1'b0;
      sec_cnt_q <= '0;
    end else begin
      primed_q <= 1'b1;
      sec_cnt_q <= sec_tick ? 25'h0 : sec_cnt_q + 25'h1;
    end
  end

  // Persistence counters and level history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        oof_prev_q[c] <= 1'b0;
        v52_prev_q[c] <= 1'b0;
        a_q[c] <= 1'b0;
        febe_q[c] <= 1'b0;
        rai_cnt_q[c] <= '0;
        febe_cnt_q[c] <= '0;
        streak_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        oof_prev_q[c] <= rx_in[c].offline_frame_loss_state;
        v52_prev_q[c] <= rx_in[c].v52_link_id_state;
        if (rx_in[c].nfas_strobe) begin
          a_q[c] <= rx_in[c].a_bit;
        end
        if (rx_in[c].e_strobe) begin
          febe_q[c] <= ~&rx_in[c].e_bits;
        end
        // Counter parks at the limit so the flag fires once per episode
        if (!(a_q[c] && febe_q[c])) begin
          rai_cnt_q[c] <= '0;
        end else if (rai_cnt_q[c] != 18'(RAI_PERSIST_CYCLES)) begin
          rai_cnt_q[c] <= rai_cnt_q[c] + 18'h1;
        end
        if (sec_tick) begin
          febe_cnt_q[c] <= '0;
          if (febe_sum[c] <= FEBE_LIMIT || ev[c][B_PFEBE]) begin
            streak_q[c] <= '0;
          end else begin
            streak_q[c] <= streak_q[c] + 3'h1;
          end
        end else begin
          febe_cnt_q[c] <= febe_sum[c];
        end
      end
    end
  end

  // Sticky flags; a new event in the read cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        flags_q[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (rd_take && ridx[6:0] == IDX_FLAGS && ridx[9:7] == 3'(c)) begin
          flags_q[c] <= ev[c];
        end else begin
          flags_q[c] <= flags_q[c] | ev[c];
        end
      end
    end
  end

  always_comb begin
    irq_n = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      if (|(flags_q[c] & irq_en_q[c])) begin
        irq_n = 1'b0;
      end
    end
  end

  // ****************************************************************
  // National nibble debounce
  // ****************************************************************
  logic [1:0] sa_cnt_q [NCH];
  logic [2:0] sa_shift_q [NCH];
  logic [3:0] sa_prev_q [NCH];
  logic sa_prev_ok_q [NCH];
  logic [3:0] sa_new [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      sa_new[c] = {sa_shift_q[c], pick_sa(nib_sel_q[c], rx_in[c].sa_bits)};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        sa_cnt_q[c] <= '0;
        sa_shift_q[c] <= '0;
        sa_prev_q[c] <= '0;
        sa_prev_ok_q[c] <= 1'b0;
        nibble_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (rx_in[c].crc_submf_start) begin
          sa_cnt_q[c] <= '0;
        end else if (rx_in[c].nfas_strobe) begin
          sa_cnt_q[c] <= sa_cnt_q[c] + 2'h1;
          sa_shift_q[c] <= sa_new[c][2:0];
          if (sa_cnt_q[c] == 2'h3) begin
            sa_prev_q[c] <= sa_new[c];
            sa_prev_ok_q[c] <= 1'b1;
            if (sa_prev_ok_q[c] && sa_prev_q[c] == sa_new[c]) begin
              nibble_q[c] <= sa_new[c];
            end
          end
        end
      end
    end
  end

  // ****************************************************************
  // Transmit overhead insertion
  // ****************************************************************
  logic [3:0] crc_run_q [NCH];
  logic [3:0] crc_hold_q [NCH];
  logic [3:0] crc_src [NCH];
  logic [7:0] out_byte [NCH];
  logic smf_start [NCH];
  logic crc_eff [NCH];

  assign tx_fifo_reinit = {tx_cfg_q[7][C_REINIT], tx_cfg_q[6][C_REINIT],
                           tx_cfg_q[5][C_REINIT], tx_cfg_q[4][C_REINIT],
                           tx_cfg_q[3][C_REINIT], tx_cfg_q[2][C_REINIT],
                           tx_cfg_q[1][C_REINIT], tx_cfg_q[0][C_REINIT]};

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      smf_start[c] = tx_in[c].ts == 5'h0 && tx_in[c].frame[2:0] == 3'h0;
      // CRC bits of the finished sub-multiframe go out in the next one
      crc_src[c] = smf_start[c] ? crc_run_q[c] : crc_hold_q[c];
      crc_eff[c] = tx_cfg_q[c][C_CRC_ON] && !tx_cfg_q[c][C_FAS_OFF] &&
                   !tx_cfg_q[c][C_XB_BYP];
      out_byte[c] = tx_in[c].data;
      if (tx_in[c].ts == 5'h0 && !tx_cfg_q[c][C_FAS_OFF]) begin
        if (!tx_in[c].frame[0]) begin
          out_byte[c][6:0] = FAS_PATTERN;
          if (crc_eff[c]) begin
            out_byte[c][7] = crc_src[c][3 - tx_in[c].frame[2:1]];
          end else if (!tx_cfg_q[c][C_XB_BYP]) begin
            out_byte[c][7] = SI_DEFAULT[1];
          end
        end else if (crc_eff[c]) begin
          if (tx_in[c].frame[3:1] < 3'h6) begin
            out_byte[c][7] = MFAS_PATTERN[5 - tx_in[c].frame[3:1]];
          end else if (!tx_cfg_q[c][C_FEBE_OFF]) begin
            out_byte[c][7] = tx_in[c].far_crc_ok[~tx_in[c].frame[1]];
          end else begin
            out_byte[c][7] = SI_DEFAULT[~tx_in[c].frame[1]];
          end
        end else if (!tx_cfg_q[c][C_XB_BYP]) begin
          out_byte[c][7] = SI_DEFAULT[0];
        end
      end
      if (tx_in[c].ts == 5'h10 && !tx_in[c].all_ones_force) begin
        if (tx_cfg_q[c][C_SRC_HI] && tx_cfg_q[c][C_SRC_LO]) begin
          out_byte[c] = tx_in[c].use_ctrl ? tx_in[c].ctrl : tx_in[c].sig;
          if (tx_in[c].sig_mf_frame0) begin
            out_byte[c] = {SIGMF_ALIGN, tx_in[c].data[3:0]};
            if (!tx_cfg_q[c][C_EXTRA_BYP] && !tx_cfg_q[c][C_FAS_OFF]) begin
              out_byte[c][3] = EXTRA_DEFAULT[2];
              out_byte[c][1] = EXTRA_DEFAULT[1];
              out_byte[c][0] = EXTRA_DEFAULT[0];
            end
          end
        end
        // Codes 00 and the reserved 01/10 leave input TS16 untouched
      end
      if (tx_in[c].all_ones_force) begin
        out_byte[c] = 8'hff;
      end
    end
  end

  // CRC runs over the sent sub-multiframe with C-bit positions as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        crc_run_q[c] <= '0;
        crc_hold_q[c] <= '0;
        tx_out[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        tx_out[c].data <= out_byte[c];
        tx_out[c].valid <= tx_in[c].valid && !tx_cfg_q[c][C_REINIT];
        if (tx_cfg_q[c][C_REINIT]) begin
          crc_run_q[c] <= '0;
          crc_hold_q[c] <= '0;
        end else if (tx_in[c].valid) begin
          if (smf_start[c]) begin
            crc_hold_q[c] <= crc_run_q[c];
            crc_run_q[c] <= crc4_byte(4'h0, {1'b0, out_byte[c][6:0]});
          end else if (tx_in[c].ts == 5'h0 && !tx_in[c].frame[0]) begin
            crc_run_q[c] <= crc4_byte(crc_run_q[c], {1'b0, out_byte[c][6:0]});
          end else begin
            crc_run_q[c] <= crc4_byte(crc_run_q[c], out_byte[c]);
          end
        end
      end
    end
  end

endmodule : e1_ovh_core
`default_nettype wire

/* File: tb/e1_ovh_assertions.sv */
// Port-level checks for the E1 overhead block, bound onto its top module.
// Assumes the transmit path of channel 0 carries the traffic of interest.
`timescale 1ns/1ns
`default_nettype none
module e1_ovh_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmit path and interrupt
  input wire e1_ovh_pkg::tx_in_t tx_in [e1_ovh_pkg::NCH],
  input wire e1_ovh_pkg::tx_out_t tx_out [e1_ovh_pkg::NCH],
  input wire logic [e1_ovh_pkg::NCH-1:0] tx_fifo_reinit,
  input wire logic irq_n
);
  import e1_ovh_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence tx_taken;
    tx_in[0].valid && !tx_fifo_reinit[0] ##1 !tx_fifo_reinit[0];
  endsequence
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("refused read returned data");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_tx_latency: assert property (tx_taken |-> tx_out[0].valid)
    else $error("transmit byte lost");
  chk_reinit_blocks: assert property (tx_fifo_reinit[0] |=> !tx_out[0].valid)
    else $error("byte sent while generator held");
  chk_irq_reset: assert property (!$past(aresetn) |-> irq_n)
    else $error("interrupt active after reset");
endmodule : e1_ovh_assertions
`default_nettype wire

/* File: tb/e1_line_model.sv */
// Behavioural far side: receive framer strobes and transmit byte stream, channel 0 only.
// Assumes the caller invokes its tasks just after a rising edge of aclk.
`timescale 1ns/1ns
`default_nettype none
module e1_line_model (
  // Clock
  input wire logic aclk,
  // Framer streams
  output var e1_ovh_pkg::rx_in_t rx_in [e1_ovh_pkg::NCH],
  output var e1_ovh_pkg::tx_in_t tx_in [e1_ovh_pkg::NCH]
);
  import e1_ovh_pkg::*;
  // ****************************************************************
  // Stimulus tasks
  // ****************************************************************
  initial begin
    rx_in = '{default: '0};
    tx_in = '{default: '0};
  end
  // Strobes last one cycle; the two state levels persist like real line status
  task automatic rx_set(input logic [15:0] v);
    @(posedge aclk);
    rx_in[0] <= v;
    @(posedge aclk);
    rx_in[0] <= v & 16'h0003;
  endtask : rx_set
  task automatic tx_byte(input logic [3:0] f, input logic [7:0] d);
    @(posedge aclk);
    tx_in[0].valid <= 1'b1;
    tx_in[0].frame <= f;
    tx_in[0].data <= d;
    @(posedge aclk);
    tx_in[0].valid <= 1'b0;
  endtask : tx_byte
endmodule : e1_line_model
`default_nettype wire

/* File: tb/e1_framer_events_and_tx_overhead_tb_top.sv */
// Self-checking bench: register access over AXI4-Lite, receive events, transmit overhead.
// Assumes the core, its package, the line model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module e1_framer_events_and_tx_overhead_tb_top;
  import e1_ovh_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic [NCH-1:0] tx_fifo_reinit;
  rx_in_t rx_in [NCH];
  tx_in_t tx_in [NCH];
  tx_out_t tx_out [NCH];
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] cf [3] = '{8'h01, 8'h03, 8'h09};
  logic [7:0] dt [3] = '{8'h00, 8'h00, 8'h5a};
  logic [7:0] ex [3] = '{8'h9b, 8'h1b, 8'h5a};
  always #25 aclk = ~aclk;
  e1_ovh_core #(.RAI_PERSIST_CYCLES(20), .ONE_SECOND_CYCLES(1000)) e1_ovh_core_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_in, .tx_in, .tx_out, .tx_fifo_reinit, .irq_n);
  e1_line_model line_inst (.aclk, .rx_in, .tx_in);
  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [11:0] ad(input int ch, input int idx);
    return 12'((idx + CH_STRIDE * ch) * 4);
  endfunction : ad
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 50) begin
      n_errors++;
      test_done();
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 50) begin
      n_errors++;
      test_done();
    end
  endtask : rd
  // One sub-multiframe of Sa4 bits, first bit sent first
  task automatic submf(input logic [3:0] n);
    int j;
    line_inst.rx_set(16'h4000);
    for (j = 3; j >= 0; j--) line_inst.rx_set(16'h0800 | (16'(n[j]) << 10));
  endtask : submf
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ad(0, IDX_TX_CFG), rv, rr);
    chk("config reset", rv, 32'h60);
    rd(ad(2, IDX_IRQ_EN), rv, rr);
    chk("enable reset", rv, 32'h0);
    rd(ad(0, IDX_FLAGS), rv, rr);
    wr(ad(1, IDX_IRQ_EN), 8'h3c, rr);
    wr(ad(0, IDX_IRQ_EN), 8'h07, rr);
    rd(ad(1, IDX_IRQ_EN), rv, rr);
    chk("enable ch1", rv, 32'h3c);
    rd(ad(0, IDX_IRQ_EN), rv, rr);
    chk("enable ch0", rv, 32'h07);
    for (int i = 0; i < 4; i++) begin
      line_inst.rx_set(16'h8000 >> i);
      #1 chk("irq", irq_n, 32'(i == 0));
      rd(ad(0, IDX_FLAGS), rv, rr);
      chk("boundary flag", rv, 32'h8 >> i);
      rd(ad(0, IDX_FLAGS), rv, rr);
      chk("flags cleared", rv, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      line_inst.rx_set(16'({i == 0, i == 2}));
      rd(ad(0, IDX_FLAGS), rv, rr);
      chk("level flag", rv, i < 2 ? 32'h80 : 32'h10);
    end
    wr(ad(0, IDX_NIB_SEL), 8'h80, rr);
    for (int i = 0; i < 4; i++) begin
      submf(i < 2 ? 4'ha : 4'h5);
      rd(ad(0, IDX_NIBBLE), rv, rr);
      if (i > 0) chk("nibble", rv, i < 3 ? 32'ha : 32'h5);
    end
    wr(ad(0, IDX_NIBBLE), 8'hff, rr);
    chk("ro write", rr, RESP_SLVERR);
    rd(12'h000, rv, rr);
    chk("unmapped", {rr, rv[29:0]}, {RESP_SLVERR, 30'h0});
    wr(ad(0, IDX_TX_CFG), 8'h80, rr);
    chk("reinit pin", tx_fifo_reinit[0], 32'h1);
    line_inst.tx_byte(4'h0, 8'h00);
    #1 chk("held output", tx_out[0].valid, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(ad(0, IDX_TX_CFG), cf[i], rr);
      line_inst.tx_byte(4'h0, dt[i]);
      #1 chk("tx byte", {tx_out[0].valid, tx_out[0].data}, {1'b1, ex[i]});
    end
    repeat (3100) line_inst.rx_set(16'h0830);
    rd(ad(0, IDX_FLAGS), rv, rr);
    chk("alarms", rv, 32'h64);
    test_done();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    n_errors++;
    test_done();
  end
endmodule : e1_framer_events_and_tx_overhead_tb_top
bind e1_ovh_core e1_ovh_assertions e1_ovh_assertions_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_in, .tx_out,
  .tx_fifo_reinit, .irq_n);
`default_nettype wire
